// [src/tms_pkg.sv]
/*
  Package for the two-wire master sequence control block: register offsets,
  control field positions, reset values and timing counts.
  Assumes a 32-bit AXI4-Lite register bus and a 100 MHz module clock.
*/
package tms_pkg;
  // Byte address of the master control register.
  localparam logic [7:0] CTRL_OFF      = 8'h00;
  // Byte address of the status register, which shows the line state.
  localparam logic [7:0] STAT_OFF      = 8'h04;
  // Byte address of the last received byte.
  localparam logic [7:0] RXD_OFF       = 8'h08;
  // Field positions inside the control register.
  localparam int         START_BIT     = 0;
  localparam int         RESTART_BIT   = 1;
  localparam int         STOP_BIT      = 2;
  localparam int         RX_BIT        = 3;
  localparam int         ACK_GO_BIT    = 4;
  localparam int         ACK_VAL_BIT   = 5;
  localparam int         MASTER_BIT    = 6;
  // Reset value of the control register.
  localparam logic [15:0] CTRL_RST     = 16'h0000;
  // Clock period in ns and the quarter bit time in ns.
  localparam int         CLK_NS        = 10;
  localparam int         QTR_NS        = 2500;
  // Quarter bit time in clock cycles, rounded down, at least one.
  localparam int         QTR_CYC       = (QTR_NS / CLK_NS) < 1 ? 1 : (QTR_NS / CLK_NS);
  // AXI response codes.
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // Sequencer phases.
  typedef enum logic [2:0] {
    TMS_IDLE, TMS_START, TMS_RESTART, TMS_STOP, TMS_RX, TMS_ACK
  } tms_state_t;

  // Pin outputs travel together.
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } tms_pins_t;
endpackage : tms_pkg

// [src/tms_master_seq.sv]
/*
  Master sequence control of a two-wire serial controller behind AXI4-Lite.
  Assumes open-drain lines with pull-ups outside; the lines come in unsynchronised.
*/
// Notes on behaviour
// - ack_value one sends NACK, zero ACK.
// - ack controls act only as receiving master.
// - ack_go sends acknowledge, cleared when done.
// - rx_byte_go receives one byte, cleared after eighth.
// - stop_go makes Stop, cleared when done.
// - restart_go makes Repeated Start, cleared when done.
// - start_go makes Start, cleared when done.
// - go bits read zero when idle.
`timescale 1ns/1ps
module tms_master_seq #(
  parameter int QTR = tms_pkg::QTR_CYC
) (
  // Clock, reset and clock enable.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite write channels.
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // Serial lines, open drain: the enable pulls the line low.
  input  wire logic        serial_clock_line_i,
  output logic             serial_clock_line_o,
  output logic             serial_clock_line_oe,
  input  wire logic        serial_data_line_i,
  output logic             serial_data_line_o,
  output logic             serial_data_line_oe
);
  // Line synchronisers, two flops each.
  logic [1:0]        scl_sy_q, sda_sy_q;
  // Control register, receive data, sequencer state.
  logic [15:0]       ctrl_q;
  logic [7:0]        rxd_q;
  tms_pkg::tms_state_t st_q;
  logic [1:0]        ph_q;       // Quarter-bit phase inside a sequence.
  logic [15:0]       cnt_q;      // Quarter-bit timer.
  logic [3:0]        bit_q;      // Received bit count.
  tms_pkg::tms_pins_t pins_q;
  // Bus latches.
  logic              aw_q, w_q;
  logic [7:0]        awa_q;
  logic [31:0]       wd_q;
  logic [3:0]        ws_q;

  // Synchronise the lines before anything looks at them.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_sy_q <= 2'b11;
      sda_sy_q <= 2'b11;
    end else if (ce) begin
      scl_sy_q <= {scl_sy_q[0], serial_clock_line_i};
      sda_sy_q <= {sda_sy_q[0], serial_data_line_i};
    end
  end
  wire scl_s = scl_sy_q[1];
  wire sda_s = sda_sy_q[1];

  // Decode of bus events.
  wire        wr_go   = aw_q && w_q && !s_bvalid;
  wire        wr_ctrl = wr_go && (awa_q == tms_pkg::CTRL_OFF) && ws_q[0];
  wire        wr_ok   = (awa_q == tms_pkg::CTRL_OFF) || (awa_q == tms_pkg::STAT_OFF)
                        || (awa_q == tms_pkg::RXD_OFF);
  // Receive and acknowledge go bits are dropped unless the same write keeps
  // the master bit set, so a refused request never leaves a stuck go bit.
  wire [7:0]  ctrl_wr = {wd_q[7:5], wd_q[4:3] & {2{wd_q[tms_pkg::MASTER_BIT]}},
                         wd_q[2:0]};
  wire        rd_go   = s_arvalid && !s_rvalid;
  wire        tick    = (cnt_q == 16'h0000);
  wire        master  = ctrl_q[tms_pkg::MASTER_BIT];
  wire [4:0]  go_bits = ctrl_q[4:0];
  // Sequence ends on the last tick of its last phase.
  wire        seq_end = (st_q != tms_pkg::TMS_IDLE) && tick && (ph_q == 2'd3)
                        && (st_q != tms_pkg::TMS_RX || bit_q == 4'd7);
  wire [31:0] rd_mux  = (s_araddr == tms_pkg::CTRL_OFF) ? {16'h0000, ctrl_q} :
                        (s_araddr == tms_pkg::STAT_OFF) ? {28'h000_0000, 1'b0,
                         st_q != tms_pkg::TMS_IDLE, scl_s, sda_s} :
                        (s_araddr == tms_pkg::RXD_OFF)  ? {24'h00_0000, rxd_q} :
                        32'h0000_0000;
  wire        rd_ok   = (s_araddr == tms_pkg::CTRL_OFF) || (s_araddr == tms_pkg::STAT_OFF)
                        || (s_araddr == tms_pkg::RXD_OFF);

  // Write address and data are taken in either order and held until both are in.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q  <= 1'b0;
      w_q   <= 1'b0;
      awa_q <= 8'h00;
      wd_q  <= 32'h0000_0000;
      ws_q  <= 4'h0;
    end else if (ce) begin
      if (s_awvalid && s_awready) begin
        aw_q  <= 1'b1;
        awa_q <= s_awaddr;
      end else if (wr_go) begin
        aw_q <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_q  <= 1'b1;
        wd_q <= s_wdata;
        ws_q <= s_wstrb;
      end else if (wr_go) begin
        w_q <= 1'b0;
      end
    end
  end

  // Write response and read answer; unmapped addresses answer with a slave error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= tms_pkg::RESP_OKAY;
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= tms_pkg::RESP_OKAY;
    end else if (ce) begin
      s_awready <= !aw_q && !s_awready && !s_bvalid;
      s_wready  <= !w_q && !s_wready && !s_bvalid;
      if (wr_go) begin
        s_bvalid <= 1'b1;
        s_bresp  <= wr_ok ? tms_pkg::RESP_OKAY : tms_pkg::RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
      s_arready <= rd_go && !s_arready;
      if (rd_go && !s_arready) begin
        s_rvalid <= 1'b1;
        s_rdata  <= rd_mux;
        s_rresp  <= rd_ok ? tms_pkg::RESP_OKAY : tms_pkg::RESP_SLVERR;
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // Control register: software writes, hardware clears all five go bits when
  // any sequence ends. Go bits only start anything while idle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= tms_pkg::CTRL_RST;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_q[7:0] <= ctrl_wr;
      end
      if (seq_end) begin
        ctrl_q[4:0] <= 5'b00000;
      end
      if (ws_q[1] && wr_go && awa_q == tms_pkg::CTRL_OFF) begin
        ctrl_q[15:8] <= wd_q[15:8];
      end
    end
  end

  // Sequencer: each sequence is four quarter-bit phases (receive: per bit).
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q   <= tms_pkg::TMS_IDLE;
      ph_q   <= 2'd0;
      cnt_q  <= 16'h0000;
      bit_q  <= 4'h0;
      rxd_q  <= 8'h00;
      pins_q <= '0;
    end else if (ce) begin
      cnt_q <= tick ? 16'(QTR - 1) : cnt_q - 16'h0001;
      unique case (st_q)
        tms_pkg::TMS_IDLE: begin
          ph_q  <= 2'd0;
          bit_q <= 4'h0;
          if (go_bits[tms_pkg::START_BIT])        st_q <= tms_pkg::TMS_START;
          else if (go_bits[tms_pkg::RESTART_BIT]) st_q <= tms_pkg::TMS_RESTART;
          else if (go_bits[tms_pkg::STOP_BIT])    st_q <= tms_pkg::TMS_STOP;
          else if (go_bits[tms_pkg::RX_BIT] && master) st_q <= tms_pkg::TMS_RX;
          else if (go_bits[tms_pkg::ACK_GO_BIT] && master) st_q <= tms_pkg::TMS_ACK;
        end
        default: begin
          if (tick) begin
            ph_q <= ph_q + 2'd1;
            if (seq_end) st_q <= tms_pkg::TMS_IDLE;
          end
        end
      endcase
      // Line drive by sequence and phase; oe high pulls the line low.
      if (tick) begin
        unique case (st_q)
          tms_pkg::TMS_START: pins_q <= '{scl_oe: ph_q == 2'd3, sda_oe: ph_q >= 2'd1};
          tms_pkg::TMS_RESTART: pins_q <= '{scl_oe: ph_q == 2'd0 || ph_q == 2'd3,
                                            sda_oe: ph_q >= 2'd2};
          tms_pkg::TMS_STOP: pins_q <= '{scl_oe: ph_q == 2'd0, sda_oe: ph_q <= 2'd1};
          tms_pkg::TMS_RX: begin
            pins_q <= '{scl_oe: ph_q == 2'd0 || ph_q == 2'd3, sda_oe: 1'b0};
            if (ph_q == 2'd2) rxd_q <= {rxd_q[6:0], sda_s};
            if (ph_q == 2'd3) bit_q <= bit_q + 4'h1;
          end
          tms_pkg::TMS_ACK: pins_q <= '{scl_oe: ph_q == 2'd0 || ph_q == 2'd3,
                                        sda_oe: !ctrl_q[tms_pkg::ACK_VAL_BIT]};
          default: pins_q <= pins_q;
        endcase
      end
    end
  end

  // Open-drain outputs: output value always low, enable drives.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_clock_line_o  <= 1'b0;
      serial_clock_line_oe <= 1'b0;
      serial_data_line_o   <= 1'b0;
      serial_data_line_oe  <= 1'b0;
    end else if (ce) begin
      serial_clock_line_oe <= pins_q.scl_oe;
      serial_data_line_oe  <= pins_q.sda_oe;
    end
  end

  // Assertions.
  property p_go_clear;
    @(posedge aclk) disable iff (!aresetn)
    (ce && seq_end && !wr_ctrl) |=> (ctrl_q[4:0] == 5'b00000);
  endproperty
  a_go_clear: assert property (p_go_clear) else $error("go bit not cleared");
  property p_ack_nack;
    @(posedge aclk) disable iff (!aresetn)
    (ce && tick && st_q == tms_pkg::TMS_ACK && ctrl_q[tms_pkg::ACK_VAL_BIT])
      |=> !pins_q.sda_oe;
  endproperty
  a_ack_nack: assert property (p_ack_nack) else $error("nack drove data low");
  property p_ack_master;
    @(posedge aclk) disable iff (!aresetn)
    (st_q == tms_pkg::TMS_IDLE && !master) |=>
      !(st_q inside {tms_pkg::TMS_RX, tms_pkg::TMS_ACK});
  endproperty
  a_ack_master: assert property (p_ack_master) else $error("ack outside master");
  property p_rx_bits;
    @(posedge aclk) disable iff (!aresetn)
    (st_q == tms_pkg::TMS_RX) |-> (bit_q <= 4'd7);
  endproperty
  a_rx_bits: assert property (p_rx_bits) else $error("more than eight bits");
  property p_start;
    @(posedge aclk) disable iff (!aresetn)
    (ce && st_q == tms_pkg::TMS_IDLE && go_bits[tms_pkg::START_BIT])
      |=> st_q == tms_pkg::TMS_START;
  endproperty
  a_start: assert property (p_start) else $error("start not launched");
  property p_stop_end;
    @(posedge aclk) disable iff (!aresetn)
    (ce && st_q == tms_pkg::TMS_STOP && seq_end) |=> st_q == tms_pkg::TMS_IDLE;
  endproperty
  a_stop_end: assert property (p_stop_end) else $error("stop did not end");
  property p_restart;
    @(posedge aclk) disable iff (!aresetn)
    (ce && st_q == tms_pkg::TMS_IDLE && go_bits[1:0] == 2'b10)
      |=> st_q == tms_pkg::TMS_RESTART;
  endproperty
  a_restart: assert property (p_restart) else $error("restart not launched");
  property p_ack_go;
    @(posedge aclk) disable iff (!aresetn)
    (ce && st_q == tms_pkg::TMS_IDLE && master && go_bits == 5'b10000)
      |=> st_q == tms_pkg::TMS_ACK;
  endproperty
  a_ack_go: assert property (p_ack_go) else $error("ack not launched");
endmodule : tms_master_seq

// [verif/tms_target_model.sv]
/*
  Target model on the two-wire bus: counts Start and Stop conditions, sends one
  byte on request and records the acknowledge level the master returns.
  Assumes pull-ups outside, so a line is high unless some party pulls it low.
*/
`timescale 1ns/1ps
module tms_target_model (
  // Wire levels and this model's pull on the data line.
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_pull,
  // Byte to send, armed while tx_en is high.
  input  wire logic       tx_en,
  input  wire logic [7:0] tx_byte,
  // Seen events.
  output int              n_start,
  output int              n_stop,
  output logic            ack_bit
);
  int bit_idx = 8; // Data bit now presented, counted from the top; 8 means the line is released.
  initial begin
    n_start = 0;
    n_stop = 0;
    sda_pull = 1'b0;
  end
  // Data falling while the clock is high opens a frame, rising closes it.
  always @(negedge sda) if (scl === 1'b1) n_start++;
  always @(posedge sda) if (scl === 1'b1) n_stop++;
  // Arming presents the top bit at once, while the master holds the clock low.
  always @(posedge tx_en) begin
    bit_idx = 0;
    ack_bit = 1'bx;
    sda_pull = !tx_byte[7];
  end
  // Each falling clock moves to the next bit; after the eighth the line is freed.
  always @(negedge scl) if (bit_idx < 8) begin
    bit_idx++;
    sda_pull = (bit_idx < 8) ? !tx_byte[7 - bit_idx] : 1'b0;
  end
  // The ninth rising clock carries the master's acknowledge level.
  always @(posedge scl) if (bit_idx == 8 && tx_en) ack_bit = sda;
endmodule : tms_target_model

// [verif/tms_master_seq_bench.sv]
/*
  Bench for the master sequence control: runs Start, receive, acknowledge,
  Repeated Start and Stop over AXI4-Lite against the target model.
  Assumes the hand-over timing of the bus and a shortened quarter bit time.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module tms_master_seq_bench;
  // Bench-driven inputs, valued at time zero except av and rdat.
  logic        aclk = 0, aresetn = 0, ce = 1, tx_en = 0, av;
  logic [7:0]  s_awaddr = 0, s_araddr = 0, tx_byte = 0;
  logic [31:0] s_wdata = 0, rdat;
  logic [3:0]  s_wstrb = 4'hf;
  logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  // Design answers and wire levels.
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic        scl_oe, sda_oe, sda_pull, ack_bit, scl_o, sda_o;
  logic [1:0]  s_bresp, s_rresp, resp;
  logic [31:0] s_rdata;
  wire         scl = !scl_oe;
  wire         sda = !(sda_oe || sda_pull);
  int          n_start, n_stop, n_fail = 0, num_checks = 0, cyc = 0, seed = 32'h2f84;
  // Start and Stop counts seen before the first sequence, from the power-up edge.
  int          s0, p0;

  tms_master_seq #(.QTR(4)) dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .serial_clock_line_i(scl), .serial_clock_line_o(scl_o), .serial_clock_line_oe(scl_oe),
    .serial_data_line_i(sda), .serial_data_line_o(sda_o), .serial_data_line_oe(sda_oe));
  tms_target_model tgt (.scl(scl), .sda(sda), .sda_pull(sda_pull), .tx_en(tx_en),
    .tx_byte(tx_byte), .n_start(n_start), .n_stop(n_stop), .ack_bit(ack_bit));

  always #5 aclk = !aclk;
  // A hang is cut short long after the expected thirteen hundred or so cycles.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  // One write: both channels offered together, each released when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    fork
      begin do @(posedge aclk); while (s_awready !== 1'b1); s_awvalid <= 1'b0; end
      begin do @(posedge aclk); while (s_wready !== 1'b1); s_wvalid <= 1'b0; end
    join
    while (s_bvalid !== 1'b1) @(posedge aclk);
    r = s_bresp;
    s_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  // One read, data taken at the edge where rvalid is seen.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge aclk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    while (s_rvalid !== 1'b1) @(posedge aclk);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // Sets one go bit as master, then polls until hardware clears it.
  task automatic go(input int b, input logic v);
    wr(tms_pkg::CTRL_OFF, 32'h0000_0040 | (32'(v) << 5) | (32'h1 << b), resp);
    `CHK(resp, tms_pkg::RESP_OKAY)
    do rd(tms_pkg::CTRL_OFF, rdat, resp); while (rdat[b] !== 1'b0);
    `CHK(rdat[4:0], 5'h00)
  endtask : go

  // NACK leaves the line high, ACK pulls it low.
  function automatic logic exp_ack(input logic v);
    return v;
  endfunction : exp_ack

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(tms_pkg::CTRL_OFF, rdat, resp);
    `CHK(rdat[15:0], tms_pkg::CTRL_RST)
    `CHK(resp, tms_pkg::RESP_OKAY)
    s0 = n_start;
    p0 = n_stop;
    `CHK({scl_o, sda_o}, 2'b00)
    // Receive and acknowledge requests without the master bit are dropped.
    wr(tms_pkg::CTRL_OFF, 32'h0000_0018, resp);
    rd(tms_pkg::CTRL_OFF, rdat, resp);
    `CHK(rdat[4:0], 5'h00)
    rd(tms_pkg::STAT_OFF, rdat, resp);
    `CHK(rdat[2:0], 3'b011)
    rd(8'h0c, rdat, resp);
    `CHK(resp, tms_pkg::RESP_SLVERR)
    wr(8'h10, 32'h0000_0001, resp);
    `CHK(resp, tms_pkg::RESP_SLVERR)
    $display("test reset and map done");
    // Random bytes and ack levels, with both ack levels forced first.
    for (int i = 0; i < 6; i++) begin
      tx_byte <= 8'($random(seed));
      av = (i < 2) ? 1'(i) : 1'($random(seed));
      go(tms_pkg::START_BIT, av);
      `CHK(n_start - s0, 2 * i + 1)
      tx_en <= 1'b1;
      go(tms_pkg::RX_BIT, av);
      rd(tms_pkg::RXD_OFF, rdat, resp);
      `CHK(rdat[7:0], tx_byte)
      go(tms_pkg::ACK_GO_BIT, av);
      `CHK(ack_bit, exp_ack(av))
      tx_en <= 1'b0;
      go(tms_pkg::RESTART_BIT, av);
      `CHK(n_start - s0, 2 * i + 2)
      go(tms_pkg::STOP_BIT, av);
      `CHK(n_stop - p0, i + 1)
      $display("test transfer %0d done", i);
    end
    final_report();
  end
endmodule : tms_master_seq_bench
